/* File: shared/efs_pkg.sv */
// Shared constants, layouts and carrier types of the frame FIFO status block
package efs_pkg;
	// Pointer width of the receive and transmit FIFO address spaces
	localparam int PTR_W = 11;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_RXCFG = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_RXSW  = 8'h0C;
	localparam logic [7:0] OFS_PTR   = 8'h10;

	// Control, configuration and status field positions
	localparam int CTRL_RECEIVE_ENABLE_BIT    = 0;
	localparam int CTRL_PASSBAD = 16;
	localparam int RXCFG_FLUSH  = 0;
	localparam int STAT_HALT    = 0;
	localparam int STAT_TXE     = 1;

	// Receive status word field positions
	localparam int SB_FAIL  = 30;
	localparam int SB_LEN   = 16;
	localparam int SB_ES    = 15;
	localparam int SB_BCAST = 13;
	localparam int SB_LE    = 12;
	localparam int SB_RUNT  = 11;
	localparam int SB_MCAST = 10;
	localparam int SB_LONG  = 7;
	localparam int SB_LATE  = 6;
	localparam int SB_TYPE  = 5;
	localparam int SB_WDOG  = 4;
	localparam int SB_MII   = 3;
	localparam int SB_DRIB  = 2;
	localparam int SB_CRC   = 1;

	// Frame size limits in bytes, and dribble bit counts
	localparam logic [13:0] RUNT_BYTES = 14'h0040;
	localparam logic [13:0] MAX_BYTES  = 14'h05EE;
	localparam logic [13:0] HDR_BYTES  = 14'h000E;
	localparam logic [15:0] LT_MAX     = 16'h05DC;
	localparam logic [15:0] LEN_OVH    = 16'h0012;
	localparam logic [13:0] WDOG_BYTES = 14'h0800;
	localparam logic [2:0]  DRIB_MII   = 3'h4;
	localparam logic [2:0]  DRIB_10M   = 3'h3;

	// Transmit command field positions
	localparam int A_SIZE  = 0;
	localparam int A_LAST  = 12;
	localparam int A_FIRST = 13;
	localparam int A_OFS   = 16;
	localparam int B_LEN   = 0;
	localparam int B_CK    = 14;

	// Values after reset
	localparam logic [PTR_W-1:0] PTR_RST = 11'h000;

	// End-of-frame report from the MAC transaction port
	typedef struct packed {
		logic        bcast;
		logic        mcast;
		logic        filt_fail;
		logic        crc_bad;
		logic        late_col;
		logic [2:0]  drib;
		logic [15:0] len_type;
	} efs_rx_end_t;

	// Bulk-out word stream from the USB receive unit
	typedef struct packed {
		logic        valid;
		logic        last;
		logic        pkt_err;
		logic [31:0] data;
	} efs_tx_wr_t;

	// Transmit command parse phase
	typedef enum logic [1:0] {tx_cmd_a, tx_cmd_b, tx_data} efs_tx_ph_t;

	// Whole state of the block
	typedef struct packed {
		logic             rx_en;
		logic             pass_bad;
		logic             flush;
		logic             halted;
		logic             halt_evt;
		logic             in_frame;
		logic [13:0]      rx_len;
		logic             er_seen;
		logic [PTR_W-1:0] rx_wr;
		logic [PTR_W-1:0] rx_hd;
		logic [PTR_W-1:0] rx_rd;
		logic [31:0]      rx_stat;
		logic             stat_vld;
		efs_tx_ph_t       tx_ph;
		logic [PTR_W-1:0] tx_cur;
		logic [PTR_W-1:0] tx_head;
		logic [31:0]      tx_a;
		logic [31:0]      tx_ref;
		logic [15:0]      tx_sum;
		logic [10:0]      tx_words;
		logic             tx_err;
		logic             a_wr;
		logic [7:0]       a_addr;
		logic [31:0]      hrdata;
	} efs_state_t;
endpackage

/* File: verilog/efs_top.sv */
// Frame FIFO status builder, flush and stop control, and bulk-out command checker
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// How it works
// RL1 - Status bit 13 marks a broadcast destination.
// RL2 - Status bit 12 marks a frame length that disagrees with length/type.
// RL3 - Bit 11 marks runts; runts forwarded only when pass-bad-frames is set.
// RL4 - Status bit 10 marks a multicast destination.
// RL5 - Bit 7 marks frames over 1518 bytes; reception goes on untruncated.
// RL6 - Status bit 6 marks a late collision.
// RL7 - Bit 5 marks length/type over 1500, never for frames under 14 bytes.
// RL8 - Bit 4 marks watchdog expiry for overlong frames.
// RL9 - Bit 3 marks any receive error strobe during the frame.
// RL10 - Bit 2 marks dribbling bits: 4 in MII mode, 3 or more at 10 Mbps.
// RL11 - Dribbling bit is suppressed whenever late collision is set.
// RL12 - Bit 1 marks CRC mismatch or a receive error strobe.
// RL13 - CRC bit is meaningless, forced low, for runt, late collision, watchdog.
// RL14 - Flush returns receive read and write pointers to reset values.
// RL15 - Host stops the receiver and waits for the halt before flushing.
// RL16 - Hardware clears the flush bit when the flush is done.
// RL17 - After receive enable clears, one halted pulse once receiver stops.
// RL18 - Host restarts reception by setting receive enable again.
// RL19 - Transmit write keeps current and head pointers, rewinds errored packets.
// RL20 - Host precedes each buffer with command word A then word B.
// RL21 - Error flag rises if word B differs within a packet, ignoring checksum bit.
// RL22 - Cumulative buffer sizes must equal the frame length field, else error.
// RL23 - Bit 15 is the OR of runt, too-long, late-collision and CRC bits.
// RL24 - Bits 29:16 carry byte count; bit 30 marks filtering failure.
// RL25 - Reserved status bits 9:8 and 0 are written as zero.
module efs_top #(
	parameter logic [13:0] WDOG_LIMIT = efs_pkg::WDOG_BYTES
) (
	// Clock and reset
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	// AHB-Lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	// MAC receive side
	input  wire logic                    rx_sof,
	input  wire logic                    rx_byte,
	input  wire logic                    rx_er,
	input  wire logic                    rx_eof,
	input  wire efs_pkg::efs_rx_end_t    rx_end,
	input  wire logic                    mii_mode,
	input  wire logic                    speed_10m,
	// Receive FIFO read side
	input  wire logic                    rx_rd_adv,
	output logic [31:0]                  rx_status,
	output logic                         rx_status_valid,
	output logic [efs_pkg::PTR_W-1:0]    rx_wr_ptr,
	output logic [efs_pkg::PTR_W-1:0]    rx_head_ptr,
	output logic [efs_pkg::PTR_W-1:0]    rx_rd_ptr,
	output logic                         receive_enable_bit,
	output logic                         receiver_halted_event,
	// USB bulk-out write side
	input  wire efs_pkg::efs_tx_wr_t     tx_wr,
	output logic [efs_pkg::PTR_W-1:0]    tx_cur_ptr,
	output logic [efs_pkg::PTR_W-1:0]    transmit_write_head_pointer,
	output logic                         transmit_error_flag
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Data words in a buffer: start offset plus size, rounded up to words
	function automatic logic [10:0] efs_words(input logic [1:0] ofs, input logic [10:0] sz);
		logic [12:0] t;
		t = 13'(ofs) + 13'(sz) + 13'h0003;
		return t[12:2];
	endfunction

	efs_pkg::efs_state_t s;
	efs_pkg::efs_state_t next_s;
	logic [31:0]         st;
	logic                runt;
	logic                long_f;
	logic                wdog;
	logic                late;
	logic                crc;
	logic                keep;
	logic                lenenc;
	logic                b_bad;
	logic                len_bad;
	logic [31:0]         b_mask;
	logic [15:0]         sum_new;
	logic [10:0]         nwords;
	logic [15:0]         len16;

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign rx_status = s.rx_stat;
	assign rx_status_valid = s.stat_vld;
	assign rx_wr_ptr = s.rx_wr;
	assign rx_head_ptr = s.rx_hd;
	assign rx_rd_ptr = s.rx_rd;
	assign receive_enable_bit = s.rx_en;
	assign receiver_halted_event = s.halt_evt;
	assign tx_cur_ptr = s.tx_cur;
	assign transmit_write_head_pointer = s.tx_head;
	assign transmit_error_flag = s.tx_err;

	////////////////////////////////////////////////////////////////////////////
	// Receive status word, built from the byte count and the end report

	always_comb begin
		len16 = {2'h0, s.rx_len};
		runt = s.rx_len < efs_pkg::RUNT_BYTES;
		long_f = s.rx_len > efs_pkg::MAX_BYTES;
		wdog = s.rx_len > WDOG_LIMIT;
		late = rx_end.late_col;
		lenenc = rx_end.len_type <= efs_pkg::LT_MAX;
		crc = (rx_end.crc_bad | s.er_seen | rx_er) & ~(runt | late | wdog); // RL12 RL13
		keep = ~runt | s.pass_bad; // RL3
		st = 32'h0000_0000; // RL25
		st[efs_pkg::SB_FAIL] = rx_end.filt_fail; // RL24
		st[efs_pkg::SB_LEN +: 14] = s.rx_len; // RL24
		st[efs_pkg::SB_BCAST] = rx_end.bcast; // RL1
		st[efs_pkg::SB_LE] = lenenc && s.rx_len >= efs_pkg::HDR_BYTES
			&& rx_end.len_type + efs_pkg::LEN_OVH != len16; // RL2
		st[efs_pkg::SB_RUNT] = runt; // RL3
		st[efs_pkg::SB_MCAST] = rx_end.mcast; // RL4
		st[efs_pkg::SB_LONG] = long_f; // RL5
		st[efs_pkg::SB_LATE] = late; // RL6
		st[efs_pkg::SB_TYPE] = ~lenenc && s.rx_len >= efs_pkg::HDR_BYTES; // RL7
		st[efs_pkg::SB_WDOG] = wdog; // RL8
		st[efs_pkg::SB_MII] = s.er_seen | rx_er; // RL9
		st[efs_pkg::SB_DRIB] = ~late && (mii_mode ? rx_end.drib == efs_pkg::DRIB_MII
			: speed_10m && rx_end.drib >= efs_pkg::DRIB_10M); // RL10 RL11
		st[efs_pkg::SB_CRC] = crc; // RL12
		st[efs_pkg::SB_ES] = runt | long_f | late | crc; // RL23
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit command checks on the incoming word

	always_comb begin
		b_mask = ~(32'h0000_0001 << efs_pkg::B_CK);
		sum_new = (s.tx_a[efs_pkg::A_FIRST] ? 16'h0000 : s.tx_sum)
			+ 16'(s.tx_a[efs_pkg::A_SIZE +: 11]);
		nwords = efs_words(s.tx_a[efs_pkg::A_OFS +: 2], s.tx_a[efs_pkg::A_SIZE +: 11]);
		b_bad = ~s.tx_a[efs_pkg::A_FIRST] && (tx_wr.data & b_mask) != s.tx_ref; // RL21
		len_bad = s.tx_a[efs_pkg::A_LAST]
			&& sum_new != 16'(tx_wr.data[efs_pkg::B_LEN +: 11]); // RL22
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		next_s.halt_evt = 1'b0;
		next_s.stat_vld = 1'b0;
		// Register writes in the data phase; error flag cleared by writing one
		if (s.a_wr) begin
			unique case (s.a_addr)
				efs_pkg::OFS_CTRL: begin
					next_s.rx_en = hwdata[efs_pkg::CTRL_RECEIVE_ENABLE_BIT]; // RL18
					next_s.pass_bad = hwdata[efs_pkg::CTRL_PASSBAD];
				end
				efs_pkg::OFS_RXCFG: next_s.flush = hwdata[efs_pkg::RXCFG_FLUSH];
				efs_pkg::OFS_STAT: begin
					if (hwdata[efs_pkg::STAT_TXE]) begin
						next_s.tx_err = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Address phase capture and read data
		next_s.a_wr = 1'b0;
		if (hsel && hready && htrans[1]) begin
			next_s.a_wr = hwrite;
			next_s.a_addr = {haddr[7:2], 2'h0};
			if (!hwrite) begin
				unique case ({haddr[7:2], 2'h0})
					efs_pkg::OFS_CTRL: next_s.hrdata = {15'h0000, s.pass_bad, 15'h0000, s.rx_en};
					efs_pkg::OFS_RXCFG: next_s.hrdata = {31'h0000_0000, s.flush};
					efs_pkg::OFS_STAT: next_s.hrdata = {30'h0000_0000, s.tx_err, s.halted};
					efs_pkg::OFS_RXSW: next_s.hrdata = s.rx_stat;
					efs_pkg::OFS_PTR: next_s.hrdata = {16'(s.rx_rd), 16'(s.rx_wr)};
					default: next_s.hrdata = 32'h0000_0000;
				endcase
			end
		end
		// Receiver stop: halt once no frame is in flight
		if (s.rx_en) begin
			next_s.halted = 1'b0;
		end else if (!s.halted && !s.in_frame) begin
			next_s.halted = 1'b1; // RL17
			next_s.halt_evt = 1'b1; // RL17
		end
		// Frame start reserves the status slot at the head
		if (rx_sof && s.rx_en && !s.in_frame && !s.flush) begin
			next_s.in_frame = 1'b1;
			next_s.rx_len = 14'h0000;
			next_s.er_seen = 1'b0;
			next_s.rx_hd = s.rx_wr;
			next_s.rx_wr = s.rx_wr + 11'h001;
		end
		// Frame body and end; the byte count runs on past 1518 bytes and saturates at 3FFF
		if (s.in_frame) begin
			if (rx_er) begin
				next_s.er_seen = 1'b1; // RL9
			end
			if (rx_byte && s.rx_len != 14'h3FFF) begin
				next_s.rx_len = s.rx_len + 14'h0001; // RL5
				if (s.rx_len[1:0] == 2'h3) begin
					next_s.rx_wr = s.rx_wr + 11'h001;
				end
			end
			if (rx_eof) begin
				next_s.in_frame = 1'b0;
				if (keep) begin
					next_s.rx_stat = st;
					next_s.stat_vld = 1'b1;
					if (s.rx_len[1:0] != 2'h0) begin
						next_s.rx_wr = s.rx_wr + 11'h001;
					end
				end else begin
					next_s.rx_wr = s.rx_hd; // RL3
				end
			end
		end
		// Read side advances only over committed words
		if (rx_rd_adv && s.rx_rd != s.rx_hd) begin
			next_s.rx_rd = s.rx_rd + 11'h001;
		end
		// Flush relies on a stopped receiver and finishes in one cycle
		if (s.flush) begin // RL15
			next_s.rx_wr = efs_pkg::PTR_RST; // RL14
			next_s.rx_hd = efs_pkg::PTR_RST; // RL14
			next_s.rx_rd = efs_pkg::PTR_RST; // RL14
			next_s.in_frame = 1'b0;
			next_s.flush = 1'b0; // RL16
		end
		// Bulk-out words are stored unchanged; the parser only watches them
		if (tx_wr.pkt_err) begin
			next_s.tx_cur = s.tx_head; // RL19
			next_s.tx_ph = efs_pkg::tx_cmd_a;
		end else if (tx_wr.valid) begin
			next_s.tx_cur = s.tx_cur + 11'h001; // RL19
			if (tx_wr.last) begin
				next_s.tx_head = s.tx_cur + 11'h001; // RL19
			end
			unique case (s.tx_ph)
				efs_pkg::tx_cmd_a: begin
					next_s.tx_a = tx_wr.data; // RL20
					next_s.tx_ph = efs_pkg::tx_cmd_b;
				end
				efs_pkg::tx_cmd_b: begin
					next_s.tx_sum = sum_new;
					next_s.tx_words = nwords;
					if (s.tx_a[efs_pkg::A_FIRST]) begin
						next_s.tx_ref = tx_wr.data & b_mask;
					end
					if (b_bad || len_bad) begin
						next_s.tx_err = 1'b1; // RL21 RL22
					end
					next_s.tx_ph = nwords == 11'h000 ? efs_pkg::tx_cmd_a : efs_pkg::tx_data;
				end
				efs_pkg::tx_data: begin
					next_s.tx_words = s.tx_words - 11'h001;
					if (s.tx_words == 11'h001) begin
						next_s.tx_ph = efs_pkg::tx_cmd_a;
					end
				end
				default: next_s.tx_ph = efs_pkg::tx_cmd_a;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.halted <= 1'b1;
			s.tx_ph <= efs_pkg::tx_cmd_a;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions and covers

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Error summary tracks its four sources
	es_summary_a: assert property (rx_status_valid |-> rx_status[15] ==
		(rx_status[11] | rx_status[7] | rx_status[6] | rx_status[1])) // RL23
		else $error("error summary wrong");
	// Dribble never with late collision
	drib_late_a: assert property (rx_status_valid && rx_status[6] |-> !rx_status[2]) // RL11
		else $error("dribble with late collision");
	// Runt dropped unless pass-bad is set
	runt_drop_a: assert property (s.in_frame && rx_eof && !s.flush && s.rx_len < 14'h0040
		&& !s.pass_bad |=> !rx_status_valid && rx_wr_ptr == $past(rx_head_ptr)) // RL3
		else $error("runt frame not dropped");
	// Flush zeroes pointers and self clears
	flush_done_a: assert property (s.flush && !s.a_wr |=> !s.flush && rx_wr_ptr == 11'h000
		&& rx_rd_ptr == 11'h000 && rx_head_ptr == 11'h000) // RL14 RL16
		else $error("flush incomplete");
	// Halt pulse is one cycle and only when disabled
	halt_pulse_a: assert property (receiver_halted_event |-> !receive_enable_bit
		##1 !receiver_halted_event) // RL17
		else $error("halt pulse wrong");
	// Frame type bit absent on short frames
	type_short_a: assert property (rx_status_valid && rx_status[29:16] < 14'h000E
		|-> !rx_status[5]) // RL7
		else $error("frame type on short frame");
	// CRC bit cleared when meaningless
	crc_void_a: assert property (rx_status_valid && (rx_status[11] | rx_status[6]
		| rx_status[4]) |-> !rx_status[1]) // RL13
		else $error("crc bit on invalid frame");
	// Too-long bit follows the byte count
	long_flag_a: assert property (rx_status_valid |-> rx_status[7] ==
		(rx_status[29:16] > 14'h05EE)) // RL5
		else $error("too long bit wrong");
	// Word B mismatch raises the error flag
	txe_set_a: assert property (tx_wr.valid && !tx_wr.pkt_err && s.tx_ph == efs_pkg::tx_cmd_b
		&& b_bad |=> transmit_error_flag) // RL21
		else $error("command mismatch missed");
	// Rewind returns to the head
	tx_rewind_a: assert property (tx_wr.pkt_err |=>
		tx_cur_ptr == $past(transmit_write_head_pointer)) // RL19
		else $error("rewind wrong");
	// Receive error strobe marks a CRC error unless the bit is meaningless
	crc_strobe_a: assert property (rx_status_valid && rx_status[3] // RL12
		&& !(rx_status[11] | rx_status[6] | rx_status[4]) |-> rx_status[1])
		else $error("receive error without crc bit");
	// Reserved status bits stay zero
	reserved_zero_a: assert property (rx_status_valid |-> rx_status[9:8] == 2'h0 // RL25
		&& !rx_status[0])
		else $error("reserved status bit set");
	// A disabled idle receiver pulses the halted event
	halt_rise_a: assert property (!receive_enable_bit && !s.halted && !s.in_frame // RL17
		|=> receiver_halted_event)
		else $error("halt pulse missing");
	// Size sum disagreeing with word B raises the error flag
	len_err_a: assert property (tx_wr.valid && !tx_wr.pkt_err // RL22
		&& s.tx_ph == efs_pkg::tx_cmd_b && len_bad |=> transmit_error_flag)
		else $error("length mismatch missed");
	// Last word of a packet moves the head to the write point
	tx_head_a: assert property (tx_wr.valid && !tx_wr.pkt_err && tx_wr.last // RL19
		|=> transmit_write_head_pointer == tx_cur_ptr)
		else $error("head pointer not moved");

	good_frame_c: cover property (rx_status_valid && !rx_status[15]);
	flush_c: cover property (s.flush);
	halt_c: cover property (receiver_halted_event);
	txe_c: cover property (!transmit_error_flag ##1 transmit_error_flag);
	drop_c: cover property (s.in_frame && rx_eof && !keep);

endmodule

/* File: test/efs_mac_model.sv */
// Behavioural MAC transaction port that feeds frames into the status block
`timescale 1ns/1ps
module efs_mac_model (
	// Clock
	input  wire logic            hclk,
	// Frame stream toward the block
	output logic                 rx_sof,
	output logic                 rx_byte,
	output logic                 rx_er,
	output logic                 rx_eof,
	output efs_pkg::efs_rx_end_t rx_end
);
	////////////////////////////////////////////////////////////////////////
	// Lines idle low before the first frame
	initial begin
		rx_sof = 1'b0;
		rx_byte = 1'b0;
		rx_er = 1'b0;
		rx_eof = 1'b0;
		rx_end = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Sends one frame of n bytes, with gap idle cycles after each byte
	task automatic send(input int n, input efs_pkg::efs_rx_end_t info, input logic er,
		input int gap);
		@(posedge hclk);
		rx_sof <= 1'b1;
		@(posedge hclk);
		rx_sof <= 1'b0;
		for (int i = 0; i < n; i++) begin
			rx_byte <= 1'b1;
			rx_er <= er && i == n / 2; // One error strobe mid-frame
			@(posedge hclk);
			if (gap > 0) begin
				rx_byte <= 1'b0;
				rx_er <= 1'b0;
				repeat (gap) @(posedge hclk);
			end
		end
		// The report is valid in the end cycle only, then turns to its inverse
		rx_byte <= 1'b0;
		rx_er <= 1'b0;
		rx_eof <= 1'b1;
		rx_end <= info;
		@(posedge hclk);
		rx_eof <= 1'b0;
		rx_end <= ~info;
	endtask
endmodule

/* File: test/eth_usb_frame_fifo_status_tb.sv */
// Self-checking bench for the frame FIFO status block
`timescale 1ns/1ps
module eth_usb_frame_fifo_status_tb;
	// One frame case beside the status word it should give
	typedef struct packed {
		logic [13:0]          n;
		efs_pkg::efs_rx_end_t e;
		logic                 er;
		logic                 mii;
		logic                 s10;
		logic [31:0]          x;
	} efs_row_t;

	logic                      hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]               haddr, hwdata, hrdata, rdv, rx_status;
	logic [1:0]                htrans;
	logic [2:0]                hsize;
	logic                      rx_sof, rx_byte, rx_er, rx_eof, mii_mode, speed_10m;
	logic                      rx_rd_adv, rx_status_valid, receive_enable_bit;
	logic                      receiver_halted_event, transmit_error_flag;
	efs_pkg::efs_rx_end_t      rx_end;
	efs_pkg::efs_tx_wr_t       tx_wr;
	logic [efs_pkg::PTR_W-1:0] rx_wr_ptr, rx_head_ptr, rx_rd_ptr, tx_cur_ptr, tx_head, w0;
	int                        n_errors, samples_checked, n_valid, n_halt, nv, nh;
	efs_row_t                  rows [14];

	////////////////////////////////////////////////////////////////////////
	// Block under test and the MAC beside it
	efs_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_sof(rx_sof),
		.rx_byte(rx_byte), .rx_er(rx_er), .rx_eof(rx_eof), .rx_end(rx_end),
		.mii_mode(mii_mode), .speed_10m(speed_10m), .rx_rd_adv(rx_rd_adv),
		.rx_status(rx_status), .rx_status_valid(rx_status_valid), .rx_wr_ptr(rx_wr_ptr),
		.rx_head_ptr(rx_head_ptr), .rx_rd_ptr(rx_rd_ptr),
		.receive_enable_bit(receive_enable_bit),
		.receiver_halted_event(receiver_halted_event), .tx_wr(tx_wr),
		.tx_cur_ptr(tx_cur_ptr), .transmit_write_head_pointer(tx_head),
		.transmit_error_flag(transmit_error_flag));
	efs_mac_model mac (.hclk(hclk), .rx_sof(rx_sof), .rx_byte(rx_byte), .rx_er(rx_er),
		.rx_eof(rx_eof), .rx_end(rx_end));

	// The single slave's ready is the bus ready
	assign hready = hreadyout;

	// Clock, 100 ns period
	always #50 hclk = ~hclk;

	// Count status and halt pulses
	always @(posedge hclk) begin
		if (rx_status_valid === 1'b1) n_valid++;
		if (receiver_halted_event === 1'b1) n_halt++;
	end

	////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Wait for ready at the next edges; only the watchdog ends a hang
	task automatic wait_ready();
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
	endtask

	// One single-word transfer; read data lands in rdv
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= 3'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rdv = hrdata;
	endtask

	// Wait for a status pulse; only the watchdog ends a hang
	task automatic wait_valid();
		while (rx_status_valid !== 1'b1) @(posedge hclk);
	endtask

	// One bulk-out word, or a rewind when e is set
	task automatic tx(input logic [31:0] d, input logic l, input logic e);
		tx_wr <= '{valid: !e, last: l, pkt_err: e, data: d};
		@(posedge hclk);
	endtask

	// Command words A and B, then nw data words
	task automatic send_buf(input logic [31:0] a, input logic [31:0] b, input int nw,
		input logic l);
		tx(a, 1'b0, 1'b0);
		tx(b, 1'b0, 1'b0);
		for (int k = 1; k <= nw; k++) tx(32'hA500 + k, l && k == nw, 1'b0);
	endtask

	// Stream idle, then let pointers settle
	task automatic tx_end();
		tx_wr <= '0;
		repeat (2) @(posedge hclk);
	endtask

	// Verdict and end of run
	task automatic report_and_stop();
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Cut a hang short well past the expected run of about eight thousand cycles
	initial begin
		#4000000;
		n_errors++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		mii_mode = 1'b1;
		speed_10m = 1'b0;
		rx_rd_adv = 1'b0;
		tx_wr = '0;
		rows = '{
			'{14'h0040, 24'h80002E, 1'b0, 1'b1, 1'b0, 32'h00402000},
			'{14'h0040, 24'h600800, 1'b0, 1'b1, 1'b0, 32'h40400420},
			'{14'h0046, 24'h10002E, 1'b0, 1'b1, 1'b0, 32'h00469002},
			'{14'h0014, 24'h100800, 1'b0, 1'b1, 1'b0, 32'h00148820},
			'{14'h000A, 24'h000800, 1'b0, 1'b1, 1'b0, 32'h000A8800},
			'{14'h0040, 24'h1C0800, 1'b0, 1'b1, 1'b0, 32'h00408060},
			'{14'h0040, 24'h040800, 1'b0, 1'b1, 1'b0, 32'h00400024},
			'{14'h0040, 24'h030800, 1'b0, 1'b1, 1'b0, 32'h00400020},
			'{14'h0040, 24'h030800, 1'b0, 1'b0, 1'b1, 32'h00400024},
			'{14'h0040, 24'h000800, 1'b1, 1'b1, 1'b0, 32'h0040802A},
			'{14'h0640, 24'h000800, 1'b0, 1'b1, 1'b0, 32'h064080A0},
			'{14'h0801, 24'h100800, 1'b0, 1'b1, 1'b0, 32'h080180B0},
			'{14'h05EE, 24'h0005DC, 1'b0, 1'b1, 1'b0, 32'h05EE0000},
			'{14'h05EF, 24'h0005DC, 1'b0, 1'b1, 1'b0, 32'h05EF9080}};
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		// Values after reset, unmapped place, enable with pass-bad-frames
		chk(rx_wr_ptr | rx_rd_ptr | rx_head_ptr | tx_cur_ptr | tx_head, 32'h0);
		chk(hresp, 32'h0);
		ahb(1'b0, efs_pkg::OFS_STAT, 32'h0);
		chk(rdv, 32'h1);
		ahb(1'b1, 8'h20, 32'hFFFFFFFF);
		ahb(1'b0, 8'h20, 32'h0);
		chk(rdv, 32'h0);
		ahb(1'b1, efs_pkg::OFS_CTRL, 32'h00010001);
		ahb(1'b0, efs_pkg::OFS_CTRL, 32'h0);
		chk(rdv, 32'h00010001);
		chk(receive_enable_bit, 32'h1);
		// Frame table
		for (int i = 0; i < 14; i++) begin
			mii_mode <= rows[i].mii;
			speed_10m <= rows[i].s10;
			w0 = rx_wr_ptr;
			mac.send(rows[i].n, rows[i].e, rows[i].er, (rows[i].n < 14'h0064) ? i % 3 : 0);
			wait_valid();
			chk(rx_status, rows[i].x);
			chk(11'(rx_wr_ptr - w0), 1 + (rows[i].n + 3) / 4);
		end
		// Runt dropped without pass-bad-frames
		ahb(1'b1, efs_pkg::OFS_CTRL, 32'h1);
		w0 = rx_wr_ptr;
		nv = n_valid;
		mac.send(20, 24'h000800, 1'b0, 0);
		repeat (3) @(posedge hclk);
		chk(n_valid - nv, 32'h0);
		chk(rx_wr_ptr, w0);
		// Read side advance
		rx_rd_adv <= 1'b1;
		repeat (3) @(posedge hclk);
		rx_rd_adv <= 1'b0;
		@(posedge hclk);
		chk(rx_rd_ptr, 32'h3);
		// Stop the receiver and see one halt pulse
		nh = n_halt;
		ahb(1'b1, efs_pkg::OFS_CTRL, 32'h0);
		repeat (4) @(posedge hclk);
		chk(n_halt - nh, 32'h1);
		ahb(1'b0, efs_pkg::OFS_STAT, 32'h0);
		chk(rdv[0], 32'h1);
		// Flush once stopped
		ahb(1'b1, efs_pkg::OFS_RXCFG, 32'h1);
		repeat (2) @(posedge hclk);
		chk({rx_wr_ptr, rx_rd_ptr}, 32'h0);
		ahb(1'b0, efs_pkg::OFS_RXCFG, 32'h0);
		chk(rdv, 32'h0);
		ahb(1'b0, efs_pkg::OFS_PTR, 32'h0);
		chk(rdv, 32'h0);
		// Restart and receive from empty
		ahb(1'b1, efs_pkg::OFS_CTRL, 32'h00010001);
		@(posedge hclk); // Halted clears one cycle after enable
		ahb(1'b0, efs_pkg::OFS_STAT, 32'h0);
		chk(rdv[0], 32'h0);
		mac.send(64, rows[0].e, 1'b0, 0);
		wait_valid();
		chk(rx_status, rows[0].x);
		chk(rx_wr_ptr, 32'h11);
		// Bulk-out: whole frame, then split frame with checksum bit differing
		send_buf(32'h00003008, 32'h00000008, 2, 1'b1);
		tx_end();
		chk(tx_cur_ptr, 32'h4);
		chk(tx_head, 32'h4);
		send_buf(32'h00002004, 32'h0000400C, 1, 1'b0);
		send_buf(32'h00001008, 32'h0000000C, 2, 1'b1);
		tx_end();
		chk(tx_head, 32'hB);
		chk(transmit_error_flag, 32'h0);
		// Errored packet rewinds to head
		send_buf(32'h00003004, 32'h00000004, 0, 1'b0);
		tx(32'h0, 1'b0, 1'b1);
		tx_end();
		chk(tx_cur_ptr, 32'hB);
		chk(transmit_error_flag, 32'h0);
		// Length disagreeing with data, then clear
		send_buf(32'h00003004, 32'h00000008, 1, 1'b1);
		tx_end();
		chk(transmit_error_flag, 32'h1);
		ahb(1'b1, efs_pkg::OFS_STAT, 32'h2);
		ahb(1'b0, efs_pkg::OFS_STAT, 32'h0);
		chk(rdv[1], 32'h0);
		// Word B differing in a non-checksum bit
		send_buf(32'h00002004, 32'h00000008, 1, 1'b0);
		send_buf(32'h00001004, 32'h00010008, 1, 1'b1);
		tx_end();
		chk(transmit_error_flag, 32'h1);
		report_and_stop();
	end
endmodule
